// >>> src/pacr_regs.v
`include "pacr_map.vh"
`default_nettype none
module pacr_regs #(
    parameter UNIT_CYCLES = (`PACR_CLK_HZ / 1000) * `PACR_UNIT_MS
) (
    // clock and reset
    input  wire        clock_i,
    input  wire        resetn_i,
    // register port
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    // format detection
    input  wire        auto_format_detect_on_i,
    input  wire        format_load_i,
    input  wire [9:0]  format_ref_div_i,
    input  wire [14:0] format_fb_div_i,
    // analog status (asynchronous)
    input  wire        ref_loop_locked_i,
    input  wire        crosspoint_hd_run_i,
    // reference loop controls
    output wire        ref_input_buffer_kind_o,
    output wire        ref_loop_halve_o,
    output wire        fast_active_o,
    output wire [4:0]  pump_code_o,
    output wire [9:0]  ref_div_o,
    output wire [14:0] fb_div_o,
    output wire [4:0]  lock_step_size_o,
    // hd loop controls
    output wire        hd_loop_halve_o,
    output wire        hd_loop_run_o
);
    reg        ref_halve_ff;
    reg        input_kind_ff;
    reg        fast_en_ff;
    reg  [3:0] fl_delay_ff;
    reg  [4:0] fast_pump_code_ff;
    reg  [4:0] normal_pump_code_ff;
    reg  [1:0] ref_div_hi_ff;
    reg  [7:0] ref_div_lo_ff;
    reg  [6:0] fb_div_hi_ff;
    reg  [7:0] fb_div_lo_ff;
    reg  [4:0] lock_step_ff;
    reg        hd_halve_ff;
    reg        hd_off_ff;
    reg  [1:0] lock_sync_ff;
    reg  [1:0] xpt_sync_ff;
    reg  [1:0] afd_sync_ff;
    reg  [7:0] nxt_rdata;

    wire       locked_s = lock_sync_ff[1];
    wire       afd_s    = afd_sync_ff[1];
    wire       expired;
    // software may only reach format-derived registers with autodetect off
    wire       sw_fmt_wr = reg_wr_i && !afd_s;

    // pins and analog flags come from other domains
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_sync_ff <= 2'h0;
            xpt_sync_ff  <= 2'h0;
            afd_sync_ff  <= 2'h0;
        end else begin
            lock_sync_ff <= {lock_sync_ff[0], ref_loop_locked_i};
            xpt_sync_ff  <= {xpt_sync_ff[0], crosspoint_hd_run_i};
            afd_sync_ff  <= {afd_sync_ff[0], auto_format_detect_on_i};
        end
    end

    // plain control registers
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_halve_ff        <= 1'b0;
            input_kind_ff       <= 1'b0;
            fast_en_ff          <= 1'b1;
            fl_delay_ff         <= `PACR_RST_FL_DELAY;
            fast_pump_code_ff   <= `PACR_RST_FAST_PUMP;
            normal_pump_code_ff <= `PACR_RST_NORM_PUMP;
            lock_step_ff        <= `PACR_RST_LOCK_STEP;
            hd_halve_ff         <= 1'b0;
            hd_off_ff           <= 1'b0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `PACR_OFS_MAIN: begin
                    ref_halve_ff  <= reg_wdata_i[`PACR_BIT_REF_HALVE];
                    input_kind_ff <= reg_wdata_i[`PACR_BIT_INPUT_KIND];
                    fast_en_ff    <= reg_wdata_i[`PACR_BIT_FAST_EN];
                end
                `PACR_OFS_FL_DELAY:  fl_delay_ff         <= reg_wdata_i[3:0];
                `PACR_OFS_FAST_PUMP: fast_pump_code_ff   <= reg_wdata_i[4:0];
                `PACR_OFS_NORM_PUMP: normal_pump_code_ff <= reg_wdata_i[4:0];
                `PACR_OFS_LOCK_STEP: lock_step_ff        <= reg_wdata_i[4:0];
                `PACR_OFS_HD_MAIN: begin
                    hd_halve_ff <= reg_wdata_i[`PACR_BIT_HD_HALVE];
                    hd_off_ff   <= reg_wdata_i[`PACR_BIT_HD_OFF];
                end
                default: begin
                end
            endcase
        end
    end

    // divider words: format load wins, software only without autodetect
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_div_hi_ff <= `PACR_RST_REF_DIV_HI;
            ref_div_lo_ff <= `PACR_RST_REF_DIV_LO;
            fb_div_hi_ff  <= `PACR_RST_FB_DIV_HI;
            fb_div_lo_ff  <= `PACR_RST_FB_DIV_LO;
        end else if (format_load_i) begin
            ref_div_hi_ff <= format_ref_div_i[9:8];
            ref_div_lo_ff <= format_ref_div_i[7:0];
            fb_div_hi_ff  <= format_fb_div_i[14:8];
            fb_div_lo_ff  <= format_fb_div_i[7:0];
        end else if (sw_fmt_wr) begin
            case (reg_addr_i)
                `PACR_OFS_REF_DIV_HI: ref_div_hi_ff <= reg_wdata_i[1:0];
                `PACR_OFS_REF_DIV_LO: ref_div_lo_ff <= reg_wdata_i;
                `PACR_OFS_FB_DIV_HI:  fb_div_hi_ff  <= reg_wdata_i[6:0];
                `PACR_OFS_FB_DIV_LO:  fb_div_lo_ff  <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // read-back; reserved bits read as zero
    always @* begin
        case (reg_addr_i)
            `PACR_OFS_MAIN:       nxt_rdata = {3'h0, ref_halve_ff, 1'b0, input_kind_ff,
                                               1'b0, fast_en_ff};
            `PACR_OFS_FL_DELAY:   nxt_rdata = {4'h0, fl_delay_ff};
            `PACR_OFS_FAST_PUMP:  nxt_rdata = {3'h0, fast_pump_code_ff};
            `PACR_OFS_NORM_PUMP:  nxt_rdata = {3'h0, normal_pump_code_ff};
            `PACR_OFS_REF_DIV_HI: nxt_rdata = {6'h00, ref_div_hi_ff};
            `PACR_OFS_REF_DIV_LO: nxt_rdata = ref_div_lo_ff;
            `PACR_OFS_FB_DIV_HI:  nxt_rdata = {1'b0, fb_div_hi_ff};
            `PACR_OFS_FB_DIV_LO:  nxt_rdata = fb_div_lo_ff;
            `PACR_OFS_LOCK_STEP:  nxt_rdata = {3'h0, lock_step_ff};
            `PACR_OFS_HD_MAIN:    nxt_rdata = {3'h0, hd_halve_ff, hd_off_ff, 3'h0};
            default:              nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end
    end

    // reserved delay codes above ten are clamped, not trusted
    wire [3:0] delay_eff = (fl_delay_ff > `PACR_MAX_DELAY_CODE) ?
                           `PACR_MAX_DELAY_CODE : fl_delay_ff;

    pacr_fast_lock_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .locked_i     (locked_s),
        .delay_code_i (delay_eff),
        .expired_o    (expired)
    );

    assign fast_active_o    = fast_en_ff && !expired;
    assign pump_code_o      = fast_active_o ? fast_pump_code_ff
                                            : normal_pump_code_ff;
    assign ref_input_buffer_kind_o = input_kind_ff;
    assign ref_loop_halve_o = ref_halve_ff;
    assign ref_div_o        = {ref_div_hi_ff, ref_div_lo_ff};
    assign fb_div_o         = {fb_div_hi_ff, fb_div_lo_ff};
    assign lock_step_size_o = lock_step_ff;
    assign hd_loop_halve_o  = hd_halve_ff;
    assign hd_loop_run_o    = !hd_off_ff && xpt_sync_ff[1];
endmodule // pacr_regs
`default_nettype wire

// >>> src/pacr_map.vh
`ifndef PACR_MAP_VH
`define PACR_MAP_VH
// register offsets (8-bit register address space)
`define PACR_OFS_MAIN        8'h25
`define PACR_OFS_FL_DELAY    8'h26
`define PACR_OFS_FAST_PUMP   8'h27
`define PACR_OFS_NORM_PUMP   8'h28
`define PACR_OFS_REF_DIV_HI  8'h29
`define PACR_OFS_REF_DIV_LO  8'h2a
`define PACR_OFS_FB_DIV_HI   8'h2b
`define PACR_OFS_FB_DIV_LO   8'h2c
`define PACR_OFS_LOCK_STEP   8'h2d
`define PACR_OFS_HD_MAIN     8'h2e
// field positions
`define PACR_BIT_REF_HALVE   4
`define PACR_BIT_INPUT_KIND  2
`define PACR_BIT_FAST_EN     0
`define PACR_BIT_HD_HALVE    4
`define PACR_BIT_HD_OFF      3
// reset values
`define PACR_RST_MAIN        8'h01
`define PACR_RST_FL_DELAY    4'h0
`define PACR_RST_FAST_PUMP   5'h1f
`define PACR_RST_NORM_PUMP   5'h08
`define PACR_RST_REF_DIV_HI  2'h0
`define PACR_RST_REF_DIV_LO  8'h01
`define PACR_RST_FB_DIV_HI   7'h06
`define PACR_RST_FB_DIV_LO   8'hb4
`define PACR_RST_LOCK_STEP   5'h08
`define PACR_RST_HD_MAIN     8'h00
// timing
`define PACR_CLK_HZ          10000000
`define PACR_UNIT_MS         500
`define PACR_MAX_DELAY_CODE  4'ha
`endif

// >>> src/pacr_fast_lock_timer.v
`default_nettype none
// counts how long the lock indication has held, in half-second units
module pacr_fast_lock_timer #(
    parameter UNIT_CYCLES = (`PACR_CLK_HZ / 1000) * `PACR_UNIT_MS
) (
    // clock and reset
    input  wire       clock_i,
    input  wire       resetn_i,
    // control
    input  wire       locked_i,
    input  wire [3:0] delay_code_i,
    // status
    output wire       expired_o
);
    reg  [22:0] tick_ff;
    reg  [3:0]  units_ff;
    reg  [22:0] nxt_tick;
    reg  [3:0]  nxt_units;

    assign expired_o = locked_i && (units_ff >= delay_code_i);

    always @* begin
        nxt_tick  = tick_ff;
        nxt_units = units_ff;
        if (!locked_i) begin
            nxt_tick  = 23'h000000;
            nxt_units = 4'h0;
        end else if (units_ff < delay_code_i) begin
            if (tick_ff == UNIT_CYCLES[22:0] - 23'h000001) begin
                nxt_tick  = 23'h000000;
                nxt_units = units_ff + 4'h1;
            end else begin
                nxt_tick = tick_ff + 23'h000001;
            end
        end
    end

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_ff  <= 23'h000000;
            units_ff <= 4'h0;
        end else begin
            tick_ff  <= nxt_tick;
            units_ff <= nxt_units;
        end
    end
endmodule // pacr_fast_lock_timer
`default_nettype wire

// >>> test/pacr_regs_chk.sv
`default_nettype none
module pacr_regs_chk (
    input wire logic        clock_i,
    input wire logic        resetn_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        auto_format_detect_on_i,
    input wire logic        format_load_i,
    input wire logic [9:0]  format_ref_div_i,
    input wire logic [14:0] format_fb_div_i,
    input wire logic        crosspoint_hd_run_i,
    input wire logic        ref_input_buffer_kind_o,
    input wire logic        ref_loop_halve_o,
    input wire logic        fast_active_o,
    input wire logic [4:0]  pump_code_o,
    input wire logic [9:0]  ref_div_o,
    input wire logic [14:0] fb_div_o,
    input wire logic [4:0]  lock_step_size_o,
    input wire logic        hd_loop_halve_o,
    input wire logic        hd_loop_run_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // a load in the same cycle wins, so such writes are left out
    wire wr_v = reg_wr_i && !format_load_i;
    wire [7:0] a = reg_addr_i;
    property p_ctl; reg_wr_i && a == 8'h25 |=> ref_input_buffer_kind_o == $past(reg_wdata_i[2])
        && ref_loop_halve_o == $past(reg_wdata_i[4]) && (fast_active_o -> $past(reg_wdata_i[0]));
    endproperty
    a_ctl: assert property (p_ctl) else $error("main control fields");
    property p_fast; (reg_wr_i && a == 8'h27) ##1 fast_active_o
        |-> pump_code_o == $past(reg_wdata_i[4:0]); endproperty
    a_fast: assert property (p_fast) else $error("fast pump code");
    property p_norm; (reg_wr_i && a == 8'h28) ##1 !fast_active_o
        |-> pump_code_o == $past(reg_wdata_i[4:0]); endproperty
    a_norm: assert property (p_norm) else $error("normal pump code");
    property p_open; !auto_format_detect_on_i [*3] ##0 (wr_v && a == 8'h2a)
        |=> ref_div_o[7:0] == $past(reg_wdata_i); endproperty
    a_open: assert property (p_open) else $error("ref divider write");
    property p_lock; auto_format_detect_on_i [*3] ##0 (wr_v && a >= 8'h29 && a <= 8'h2c)
        |=> $stable(ref_div_o) && $stable(fb_div_o); endproperty
    a_lock: assert property (p_lock) else $error("divider write not refused");
    property p_load; format_load_i |=> ref_div_o == $past(format_ref_div_i)
        && fb_div_o == $past(format_fb_div_i); endproperty
    a_load: assert property (p_load) else $error("format load");
    property p_step; reg_wr_i && a == 8'h2d |=> lock_step_size_o == $past(reg_wdata_i[4:0]);
    endproperty
    a_step: assert property (p_step) else $error("lock step size");
    property p_hd; reg_wr_i && a == 8'h2e |=> hd_loop_halve_o == $past(reg_wdata_i[4])
        && !(hd_loop_run_o && $past(reg_wdata_i[3])); endproperty
    a_hd: assert property (p_hd) else $error("hd loop control");
    property p_xpt; !crosspoint_hd_run_i [*3] |-> !hd_loop_run_o; endproperty
    a_xpt: assert property (p_xpt) else $error("hd loop runs unselected");
endmodule // pacr_regs_chk
bind pacr_regs pacr_regs_chk pacr_regs_chk_i (.*);
`default_nettype wire

// >>> test/test_pacr_regs.sv
`include "pacr_map.vh"
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_pacr_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, afd = 0, ld = 0, lk = 0, xpt = 0;
    logic [7:0]  addr = 8'h00, wd = 8'h00;
    logic [9:0]  fref = 10'h000;
    logic [14:0] ffb = 15'h0000;
    wire  [7:0]  rdat;
    wire         kind, rhalf, fast, hhalf, hrun;
    wire  [4:0]  pump, step;
    wire  [9:0]  rdiv;
    wire  [14:0] fdiv;
    int          fails = 0, num_checks = 0;
    logic [7:0] rst_v [10] = '{8'h01, 8'h00, 8'h1f, 8'h08, 8'h00, 8'h01, 8'h06, 8'hb4, 8'h08, 8'h00};
    logic [7:0] wr_v [10] = '{8'hff, 8'hf3, 8'hea, 8'he3, 8'hfe, 8'h5a, 8'hff, 8'h12, 8'hf1, 8'hff};
    logic [7:0] rb_v [10] = '{8'h15, 8'h03, 8'h0a, 8'h03, 8'h02, 8'h5a, 8'h7f, 8'h12, 8'h11, 8'h18};
    always #50 clk = ~clk;
    // short unit keeps the three-unit (1.5 s) fast-lock delay to a few dozen cycles
    pacr_regs #(.UNIT_CYCLES(10)) pacr_regs_i (.clock_i(clk), .resetn_i(rst_n), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
        .auto_format_detect_on_i(afd), .format_load_i(ld), .format_ref_div_i(fref),
        .format_fb_div_i(ffb), .ref_loop_locked_i(lk), .crosspoint_hd_run_i(xpt),
        .ref_input_buffer_kind_o(kind), .ref_loop_halve_o(rhalf), .fast_active_o(fast),
        .pump_code_o(pump), .ref_div_o(rdiv), .fb_div_o(fdiv), .lock_step_size_o(step),
        .hd_loop_halve_o(hhalf), .hd_loop_run_o(hrun));
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        `CHK(rdat, e)
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        `CHK({fast, pump, rdiv, fdiv}, {1'b1, 5'h1f, 10'h001, 15'h06b4})
        for (int k = 0; k < 10; k++) rdc(8'(8'h25 + k), rst_v[k]);
        rdc(8'h24, 8'h00);
        wrr(8'h25, 8'h00);
        `CHK({fast, pump}, {1'b0, 5'h08})
        xpt <= 1'b1;
        for (int k = 0; k < 10; k++) wrr(8'(8'h25 + k), wr_v[k]);
        for (int k = 0; k < 10; k++) rdc(8'(8'h25 + k), rb_v[k]);
        `CHK({kind, rhalf, rdiv, fdiv, step}, {2'b11, 10'h25a, 15'h7f12, 5'h11})
        `CHK({hhalf, hrun, fast, pump}, {3'b101, 5'h0a})
        lk <= 1'b1;
        repeat (20) @(posedge clk);
        lk <= 1'b0;
        repeat (4) @(posedge clk);
        lk <= 1'b1;
        repeat (27) @(posedge clk);
        `CHK(fast, 1'b1)
        repeat (10) @(posedge clk);
        `CHK({fast, pump}, {1'b0, 5'h03})
        wrr(8'h28, 8'h05);
        `CHK(pump, 5'h05)
        wrr(8'h2e, 8'h00);
        repeat (3) @(posedge clk);
        `CHK(hrun, 1'b1)
        xpt <= 1'b0;
        afd <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(hrun, 1'b0)
        wrr(8'h2a, 8'h77);
        rdc(8'h2a, 8'h5a);
        wrr(8'h2c, 8'h99);
        `CHK(fdiv, 15'h7f12)
        ld <= 1'b1;
        fref <= 10'h3c5;
        ffb <= 15'h1234;
        @(posedge clk);
        ld <= 1'b0;
        @(posedge clk);
        `CHK({rdiv, fdiv}, {10'h3c5, 15'h1234})
        rdc(8'h29, 8'h03);
        afd <= 1'b0;
        repeat (3) @(posedge clk);
        wrr(8'h2c, 8'h99);
        rdc(8'h2c, 8'h99);
        wrap_up();
    end
endmodule // test_pacr_regs
`default_nettype wire
